// file: verilog/pas_consts.svh
// Constants for the amplifier stage enable and edge sloping block.
// Assumes a Wishbone slave with 32-bit data and 8-bit registers in the low byte.
`ifndef PAS_CONSTS_SVH
`define PAS_CONSTS_SVH

// Register indexes; the byte address is four times the index.
`define PAS_IDX_TX_CFG0 6'h04
`define PAS_IDX_TX_CFG1 6'h05
`define PAS_IDX_SLOPE_DIV 6'h19
`define PAS_IDX_POW_CFG0 6'h1a
`define PAS_IDX_STATUS 6'h30

// Reset values.
`define PAS_RST_TX_CFG0 8'h06
`define PAS_RST_TX_CFG1 8'h25
`define PAS_RST_SLOPE_DIV 8'h80
`define PAS_RST_POW_CFG0 8'h00

// Field positions.
`define PAS_BIT_FAILSAFE_DIS 4
`define PAS_BIT_SLOPE_EN 4
`define PAS_BIT_CMD 7
`define PAS_SET2_HI 7
`define PAS_SET2_LO 5
`define PAS_SET1_HI 4
`define PAS_SET1_LO 2
`define PAS_DIVHI_HI 1
`define PAS_DIVHI_LO 0

// Stage layout: group 0 holds stages 0 to 8, group 1 stage 9, group 2 stage 10.
`define PAS_NUM_STAGES 11
`define PAS_LEVEL_MAX 4'h0b
`define PAS_GROUP0_LAST 8
`define PAS_GROUP1_STAGE 9

`endif

// file: verilog/pas_pkg.sv
// Types for the amplifier stage enable and edge sloping block.
// Assumes pas_consts.svh is included by the design files that need numbers.
package pas_pkg;

	typedef enum logic [1:0] {
		PAS_STEADY = 2'b00,
		PAS_RISE = 2'b01,
		PAS_FALL = 2'b10
	} pas_ramp_t;

endpackage

// file: verilog/pas_top.sv
// Stage enable and ASK edge sloping control for a three-group power amplifier.
// Assumes synchronous inputs on the reference oscillator clock and a classic Wishbone master.
// Function
// - Fail-safe shutdown armed while its disable bit is 0, inactive at 1.
// - Edge sloping happens only when the sloping enable bit is 1.
// - Divider is low byte register plus bits 1:0 of power config 0.
// - Division ratio is the 10-bit code plus one.
// - Setting 2 group pattern sits in bits 7:5 of power config 0.
// - Setting 1 group pattern sits in bits 4:2 of power config 0.
// - Pattern bit n enables amplifier group n when 1.
// - Ratio oscillator cycles pass between successive stage switches.
// - Power level 1 uses setting 1, level 2 uses setting 2.
// - Armed fail-safe switches all drivers off on an error event.
`timescale 1ns/1ps
`include "pas_consts.svh"

module pas_top (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	// Wishbone slave
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	// Transmit control
	input wire logic ask_data_in,
	input wire logic power_level2_sel_in,
	input wire logic error_event_in,
	// Amplifier drive
	output logic [2:0] pa_group_en_out,
	output logic [10:0] pa_stage_en_out,
	output logic failsafe_shutdown_out
);

	logic [7:0] tx_cfg0;
	logic [7:0] tx_cfg1;
	logic [7:0] slope_div_low;
	logic [7:0] pow_cfg0;
	logic [7:0] next_tx_cfg0;
	logic [7:0] next_tx_cfg1;
	logic [7:0] next_slope_div_low;
	logic [7:0] next_pow_cfg0;
	logic [31:0] next_wb_dat;
	logic next_wb_ack;

	pas_pkg::pas_ramp_t ramp_state;
	pas_pkg::pas_ramp_t next_ramp_state;
	logic [3:0] level;
	logic [3:0] next_level;
	logic [9:0] div_cnt;
	logic [9:0] next_div_cnt;
	logic [2:0] next_group_en;
	logic [10:0] next_stage_en;
	logic next_shutdown;

	logic [5:0] reg_idx;
	logic wr_commit;
	logic failsafe_disable;
	logic edge_sloping_enable;
	logic [9:0] sloping_divider;
	logic [2:0] group_enable_set1;
	logic [2:0] group_enable_set2;
	logic [2:0] group_sel;
	logic [3:0] target_level;
	logic [10:0] stage_mask;
	logic [10:0] stage_below;

	assign reg_idx = wb_adr_in[7:2];
	// A write lands at the edge where the master sees ack high.
	assign wr_commit = wb_cyc_in & wb_stb_in & wb_we_in & wb_ack_out & wb_sel_in[0];

	assign failsafe_disable = tx_cfg0[`PAS_BIT_FAILSAFE_DIS];
	assign edge_sloping_enable = tx_cfg1[`PAS_BIT_SLOPE_EN];
	assign sloping_divider = {pow_cfg0[`PAS_DIVHI_HI:`PAS_DIVHI_LO], slope_div_low};
	assign group_enable_set2 = pow_cfg0[`PAS_SET2_HI:`PAS_SET2_LO];
	assign group_enable_set1 = pow_cfg0[`PAS_SET1_HI:`PAS_SET1_LO];
	assign group_sel = power_level2_sel_in ? group_enable_set2 : group_enable_set1;
	assign target_level = ask_data_in ? `PAS_LEVEL_MAX : 4'h0;

	// Stages of a disabled group stay off even while the level passes them.
	// The ladder lights group 0 first, so a lone upper group only turns on near full level.
	// Group to stage map
	genvar gi;
	generate
		for (gi = 0; gi < `PAS_NUM_STAGES; gi = gi + 1) begin : g_stage
			if (gi <= `PAS_GROUP0_LAST) begin : g_grp0
				assign stage_mask[gi] = group_sel[0];
			end else if (gi == `PAS_GROUP1_STAGE) begin : g_grp1
				assign stage_mask[gi] = group_sel[1];
			end else begin : g_grp2
				assign stage_mask[gi] = group_sel[2];
			end
			assign stage_below[gi] = (next_level > 4'(gi));
		end
	endgenerate

	// Register file group.
	always_comb begin
		next_tx_cfg0 = tx_cfg0;
		next_tx_cfg1 = tx_cfg1;
		next_slope_div_low = slope_div_low;
		next_pow_cfg0 = pow_cfg0;
		if (wr_commit) begin
			case (reg_idx)
				`PAS_IDX_TX_CFG0: begin
					next_tx_cfg0 = wb_dat_in[7:0];
				end
				`PAS_IDX_TX_CFG1: begin
					next_tx_cfg1 = wb_dat_in[7:0];
				end
				`PAS_IDX_SLOPE_DIV: begin
					next_slope_div_low = wb_dat_in[7:0];
				end
				`PAS_IDX_POW_CFG0: begin
					next_pow_cfg0 = wb_dat_in[7:0];
				end
				default: begin
					// Writes to unmapped or read-only indexes are dropped.
					next_tx_cfg0 = tx_cfg0;
				end
			endcase
		end
		// Command bits are not stored here, so they read back as zero.
		next_tx_cfg0[`PAS_BIT_CMD] = 1'b0;
		next_tx_cfg1[`PAS_BIT_CMD] = 1'b0;
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			tx_cfg0 <= `PAS_RST_TX_CFG0;
			tx_cfg1 <= `PAS_RST_TX_CFG1;
			slope_div_low <= `PAS_RST_SLOPE_DIV;
			pow_cfg0 <= `PAS_RST_POW_CFG0;
		end else begin
			tx_cfg0 <= next_tx_cfg0;
			tx_cfg1 <= next_tx_cfg1;
			slope_div_low <= next_slope_div_low;
			pow_cfg0 <= next_pow_cfg0;
		end
	end

	// Bus answer group. Ack is registered to keep the bus timing clean, which costs one wait state
	// on every access; the ack bit itself blocks a back-to-back ack, so a request that is still held is acked every other cycle.
	always_comb begin
		next_wb_ack = wb_cyc_in & wb_stb_in & ~wb_ack_out;
		next_wb_dat = 32'h0000_0000;
		if (next_wb_ack && !wb_we_in) begin
			case (reg_idx)
				`PAS_IDX_TX_CFG0: begin
					next_wb_dat = {24'h00_0000, tx_cfg0};
				end
				`PAS_IDX_TX_CFG1: begin
					next_wb_dat = {24'h00_0000, tx_cfg1};
				end
				`PAS_IDX_SLOPE_DIV: begin
					next_wb_dat = {24'h00_0000, slope_div_low};
				end
				`PAS_IDX_POW_CFG0: begin
					next_wb_dat = {24'h00_0000, pow_cfg0};
				end
				`PAS_IDX_STATUS: begin
					next_wb_dat = {24'h00_0000, failsafe_shutdown_out, pa_group_en_out, level};
				end
				default: begin
					next_wb_dat = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h0000_0000;
		end else begin
			wb_ack_out <= next_wb_ack;
			wb_dat_out <= next_wb_dat;
		end
	end

	// Stage ramp group. The level counts how many stages of the ladder it has passed, whether or not they are on.
	always_comb begin
		next_ramp_state = ramp_state;
		next_level = level;
		next_div_cnt = 10'h000;
		if (!edge_sloping_enable) begin
			next_level = target_level;
			next_ramp_state = pas_pkg::PAS_STEADY;
		end else begin
			case (ramp_state)
				pas_pkg::PAS_STEADY: begin
					if (target_level > level) begin
						next_ramp_state = pas_pkg::PAS_RISE;
					end else if (target_level < level) begin
						next_ramp_state = pas_pkg::PAS_FALL;
					end else begin
						next_ramp_state = pas_pkg::PAS_STEADY;
					end
				end
				pas_pkg::PAS_RISE, pas_pkg::PAS_FALL: begin
					// A data edge mid-ramp turns the ramp round from where it stands.
					if (target_level == level) begin
						next_ramp_state = pas_pkg::PAS_STEADY;
					end else if (div_cnt == sloping_divider) begin
						if (target_level > level) begin
							next_level = level + 4'h1;
							next_ramp_state = pas_pkg::PAS_RISE;
						end else begin
							next_level = level - 4'h1;
							next_ramp_state = pas_pkg::PAS_FALL;
						end
					end else begin
						// The count runs on through a reversal, so a turned ramp keeps its pace.
						next_div_cnt = div_cnt + 10'h001;
					end
				end
				default: begin
					next_ramp_state = pas_pkg::PAS_STEADY;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			ramp_state <= pas_pkg::PAS_STEADY;
			level <= 4'h0;
			div_cnt <= 10'h000;
		end else begin
			ramp_state <= next_ramp_state;
			level <= next_level;
			div_cnt <= next_div_cnt;
		end
	end

	// Drive group. Shutdown follows the error level while the disable bit is 0, with no latch; the flags that remember an error
	// live outside this block, so clearing them is what lets the drivers come back.
	// The outputs use the next level so that stage enables land on the same edge as the level.
	always_comb begin
		next_shutdown = error_event_in & ~failsafe_disable;
		next_group_en = group_sel;
		next_stage_en = stage_mask & stage_below;
		if (next_shutdown) begin
			next_group_en = 3'h0;
			next_stage_en = 11'h000;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			pa_group_en_out <= 3'h0;
			pa_stage_en_out <= 11'h000;
			failsafe_shutdown_out <= 1'b0;
		end else begin
			pa_group_en_out <= next_group_en;
			pa_stage_en_out <= next_stage_en;
			failsafe_shutdown_out <= next_shutdown;
		end
	end

endmodule

// file: bench/pas_asserts.sv
// Port-level checker for pas_top, attached by bind.
// Assumes classic Wishbone writes commit at the acknowledged edge.
`timescale 1ns/1ps
module pas_asserts (
	input wire logic clk_sys_in, rst_n_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in, wb_dat_out,
	input wire logic ask_data_in, power_level2_sel_in, error_event_in, failsafe_shutdown_out,
	input wire logic [2:0] pa_group_en_out,
	input wire logic [10:0] pa_stage_en_out
);
	logic [7:0] cfg0, pow;
	logic [2:0] grp;
	logic wr;
	assign wr = wb_cyc_in & wb_stb_in & wb_we_in & wb_ack_out & wb_sel_in[0];
	assign grp = power_level2_sel_in ? pow[7:5] : pow[4:2];
	// Shadow copies, because the checker sees only the ports.
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			cfg0 <= 8'h06;
			pow <= 8'h00;
		end else if (wr && wb_adr_in[7:2] == 6'h04) begin
			cfg0 <= wb_dat_in[7:0];
		end else if (wr && wb_adr_in[7:2] == 6'h1a) begin
			pow <= wb_dat_in[7:0];
		end
	end
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack held too long");
	a_ack_answer: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out) else $error("ack late");
	a_rd_upper: assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h00_0000) else $error("upper data set");
	a_shut_armed: assert property (error_event_in && !cfg0[4] |=> failsafe_shutdown_out)
		else $error("shutdown missing");
	a_shut_idle: assert property (!error_event_in || cfg0[4] |=> !failsafe_shutdown_out)
		else $error("shutdown spurious");
	a_drive_off: assert property (failsafe_shutdown_out |-> pa_group_en_out == 3'h0 && pa_stage_en_out == 11'h000)
		else $error("drive on in shutdown");
	a_group_sel: assert property (!failsafe_shutdown_out && $past(rst_n_in) |-> pa_group_en_out == $past(grp))
		else $error("group pattern wrong");
	a_stage_lane: assert property (pa_stage_en_out[9] |-> pa_group_en_out[1])
		else $error("stage of disabled group");
endmodule
bind pas_top pas_asserts u_chk (.*);

// file: bench/pa_stage_enable_ask_sloping_tb.sv
// Self-checking bench for pas_top with a register model.
// Assumes the bench drives every port of the block directly.
`timescale 1ns/1ps
module pa_stage_enable_ask_sloping_tb;
	logic clk_sys_in = 0, rst_n_in = 0, cyc = 0, stb = 0, we = 0, ask = 0, lvl2 = 0, err = 0, ack, shut;
	logic [7:0] adr = 0;
	logic [31:0] dat = 0, rd, dout;
	logic [2:0] grp;
	logic [10:0] stg;
	logic [7:0] m[logic [7:0]];
	int fail_count = 0, cmp_count = 0, n, t;
	pas_top dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
		.wb_adr_in(adr), .wb_sel_in(4'h1), .wb_dat_in(dat), .wb_dat_out(dout), .wb_ack_out(ack),
		.ask_data_in(ask), .power_level2_sel_in(lvl2), .error_event_in(err), .pa_group_en_out(grp),
		.pa_stage_en_out(stg), .failsafe_shutdown_out(shut));
	always #5 clk_sys_in = ~clk_sys_in;
	task print_verdict;
		$display("Compared %0d, mismatched %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task chk(input logic [31:0] s, e);
		cmp_count++;
		if (s !== e) begin
			fail_count++;
			$display("ERROR %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task cyc_n(input int k);
		repeat (k) @(posedge clk_sys_in);
	endtask
	task wb(input logic w, input logic [7:0] a, d);
		n = 0;
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		dat <= {24'h00_0000, d};
		do begin
			cyc_n(1);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) begin
			fail_count++;
			print_verdict;
		end
		rd = dout;
		cyc <= 0;
		stb <= 0;
		cyc_n(1);
	endtask
	initial begin
		cyc_n(100000);
		fail_count++;
		print_verdict;
	end
	initial begin
		void'($urandom(3133));
		cyc_n(4);
		rst_n_in <= 1;
		cyc_n(1);
		m[8'h08] = 0;
		m[8'h10] = 8'h06;
		m[8'h14] = 8'h25;
		m[8'h64] = 8'h80;
		m[8'h68] = 8'h00;
		foreach (m[a]) begin
			wb(0, a, 0);
			chk(rd, m[a]);
			t = $urandom;
			wb(1, a, t[7:0]);
			m[a] = (a == 8'h08) ? 8'h00 : (a < 8'h64) ? t[7:0] & 8'h7f : t[7:0];
			wb(0, a, 0);
			chk(rd, m[a]);
		end
		$display("Registers done");
		wb(1, 8'h14, 8'h05);
		wb(1, 8'h10, 8'h06);
		for (int g = 0; g < 16; g++) begin
			lvl2 <= g[3];
			wb(1, 8'h68, g[3] ? {g[2:0], 5'h00} : {3'h0, g[2:0], 2'h0});
			ask <= 1;
			cyc_n(3);
			chk(grp, g[2:0]);
			chk(stg, {g[2], g[1], {9{g[0]}}});
			ask <= 0;
			cyc_n(3);
			chk(stg, 0);
		end
		$display("Patterns done");
		wb(1, 8'h64, 8'h02);
		wb(1, 8'h68, 8'he1);
		wb(1, 8'h14, 8'h15);
		ask <= 1;
		cyc_n(3);
		chk(stg, 0);
		for (n = 0; !stg[0] && n < 2000; n++) cyc_n(1);
		chk(n < 2000, 1);
		for (t = 0; !stg[1] && t < 2000; t++) cyc_n(1);
		chk(t, 259);
		ask <= 0;
		cyc_n(11 * 259 + 10);
		chk(stg, 0);
		$display("Sloping done");
		wb(1, 8'h14, 8'h05);
		ask <= 1;
		err <= 1;
		cyc_n(3);
		chk(shut, 1);
		chk(grp, 0);
		wb(0, 8'hc0, 0);
		chk(rd, 32'h0000_008b);
		wb(1, 8'h10, 8'h16);
		cyc_n(2);
		chk(shut, 0);
		chk(stg, 11'h7ff);
		err <= 0;
		$display("Fail-safe done");
		print_verdict;
	end
endmodule
